// file: hw/asc_pkg.sv
// async serial channel: shared register map, fields, timing and state types
//
// What this block does
// R1 - holding write taken if holder or shifter empty
// R2 - holding-empty flag sets when byte moves on
// R3 - start bit rechecked low at 8 ticks (7.5 rounded up)
// R4 - host reads receive holder, read pops byte
// R5 - enable bit0 gates receive-ready interrupt level
// R6 - enable bit1 gates transmit-empty interrupt
// R7 - enable bit2 gates line status interrupt
// R8 - enable bit3 gates modem interrupt, upper zero
// R9 - source read reports top interrupt, clears it unless receive-ready
// R10 - source codes 6, 4, 2, 0 by priority
// R11 - source bit0 low while interrupt pending
// R12 - format bits 1..0 pick 5 to 8 bits
// R13 - format bit2 picks one, 1.5 or 2 stops
// R14 - format bit3 adds and checks parity
// R15 - format bit4 picks odd or even parity
// R16 - format bit5 forces a constant parity bit
// R17 - format bit6 holds the line low (break) outside loop-back
// R18 - format bit7 maps divisor latch bytes in
// R19 - modem bits 0,1 drive ready/request low outside loop-back
// R20 - modem bit3 enables the interrupt pin driver
// R21 - modem bit4 loops back, upper bits zero
// R22 - loop-back takes ring and carrier from modem bits
// R23 - loop-back status mirrors modem control bits
// R24 - line status shows empty and ready bits
// R25 - overrun flagged, held byte kept intact
// R26 - frames idle high, lsb first, 16 ticks
package asc_pkg;
	localparam int unsigned ADDR_W = 5;             // apb byte address width
	// register indices; byte address is four times the index
	localparam logic [2:0] IDX_DATA = 3'h0;
	localparam logic [2:0] IDX_IER  = 3'h1;
	localparam logic [2:0] IDX_ISR  = 3'h2;
	localparam logic [2:0] IDX_LCR  = 3'h3;
	localparam logic [2:0] IDX_MCR  = 3'h4;
	localparam logic [2:0] IDX_LSR  = 3'h5;
	localparam logic [2:0] IDX_MSR  = 3'h6;
	// field positions
	localparam int unsigned IER_RX = 0, IER_TX = 1, IER_LS = 2, IER_MS = 3;
	localparam int unsigned LCR_STB = 2, LCR_PEN = 3, LCR_EVEN = 4, LCR_STICK = 5;
	localparam int unsigned LCR_BRK = 6, LCR_DLAB = 7;
	localparam int unsigned MCR_DTR = 0, MCR_RTS = 1, MCR_RING = 2, MCR_IRQEN = 3;
	localparam int unsigned MCR_LOOP = 4;
	localparam int unsigned PIN_CTS = 0, PIN_DSR = 1, PIN_RI = 2, PIN_CD = 3, PIN_RX = 4;
	// reset values
	localparam logic [3:0]  IER_RST = 4'h0;
	localparam logic [7:0]  LCR_RST = 8'h00;
	localparam logic [4:0]  MCR_RST = 5'h00;
	localparam logic [15:0] DIV_RST = 16'h0001;
	localparam logic [4:0]  PIN_RST = 5'h1f;         // all pins idle high
	// interrupt source codes, highest priority first
	localparam logic [3:0] ISR_LS   = 4'h6;
	localparam logic [3:0] ISR_RX   = 4'h4;
	localparam logic [3:0] ISR_TX   = 4'h2;
	localparam logic [3:0] ISR_MS   = 4'h0;
	localparam logic [3:0] ISR_NONE = 4'h1;
	// timing in 16x ticks
	localparam int unsigned OVS_TICKS   = 16;
	localparam int unsigned START_TENTHS = 75;      // 7 1/2 ticks
	localparam int unsigned START_TICKS = (START_TENTHS + 9) / 10;
	localparam int unsigned STOP1_TICKS = 16;
	localparam int unsigned STOP15_TICKS = 24;
	localparam int unsigned STOP2_TICKS = 32;
	// register selection after decode
	typedef enum logic [3:0] {
		SEL_RHR = 4'b0000, SEL_IER = 4'b0001, SEL_ISR = 4'b0010, SEL_LCR = 4'b0011,
		SEL_MCR = 4'b0100, SEL_LSR = 4'b0101, SEL_MSR = 4'b0110, SEL_DLL = 4'b0111,
		SEL_DLM = 4'b1000, SEL_NONE = 4'b1111
	} asc_sel_t;
	// serial engine states, shared by both directions
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000, ST_START = 3'b001, ST_DATA = 3'b010, ST_PAR = 3'b011,
		ST_STOP = 3'b100
	} asc_state_t;
endpackage : asc_pkg

// file: hw/asc_top.sv
// async serial channel: apb registers, transmitter, receiver, interrupt source logic
//
// The address map and the APB slave port were chosen for this implementation.
module asc_top #(
	parameter logic [15:0] DIV_INIT = asc_pkg::DIV_RST  // divisor after reset
) (
	input  wire logic                       pclk,
	input  wire logic                       presetn,
	input  wire logic [asc_pkg::ADDR_W-1:0] paddr,
	input  wire logic                       psel,
	input  wire logic                       penable,
	input  wire logic                       pwrite,
	input  wire logic [31:0]                pwdata,
	output logic      [31:0]                prdata,
	output logic                            pready,
	output logic                            pslverr,
	input  wire logic                       serial_in,
	output logic                            serial_out,
	input  wire logic                       cts_n,
	input  wire logic                       dsr_n,
	input  wire logic                       bell_signal_in_n,
	input  wire logic                       carrier_detect_in_n,
	output logic                            dtr_n,
	output logic                            rts_n,
	output logic                            irq_o,
	output logic                            irq_oe
);
	import asc_pkg::*;

	if (DIV_INIT == 16'h0000) begin : g_bad_div
		$error("DIV_INIT must be nonzero");
	end

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	// address to register; dlab swaps the first two for the divisor
	function automatic asc_sel_t dec_reg(input logic [ADDR_W-1:0] a, input logic dlab);
		asc_sel_t s;
		s = SEL_NONE;
		if (a[1:0] == 2'b00) begin
			case (a[4:2])
				IDX_DATA: s = dlab ? SEL_DLL : SEL_RHR; // R18
				IDX_IER:  s = dlab ? SEL_DLM : SEL_IER; // R18
				IDX_ISR:  s = SEL_ISR;
				IDX_LCR:  s = SEL_LCR;
				IDX_MCR:  s = SEL_MCR;
				IDX_LSR:  s = SEL_LSR;
				IDX_MSR:  s = SEL_MSR;
				default:  s = SEL_NONE;
			endcase
		end
		return s;
	endfunction : dec_reg

	// parity bit for a character under the current format
	function automatic logic par_of(input logic [7:0] d, input logic [7:0] fmt);
		logic [7:0] m;
		m = d & (8'hff >> (2'd3 - fmt[1:0])); // R12
		if (fmt[LCR_STICK]) begin
			return ~fmt[LCR_EVEN]; // R16
		end
		return fmt[LCR_EVEN] ? ^m : ~^m; // R15
	endfunction : par_of

	// ----------------------------------------------------------------
	// declarations
	// ----------------------------------------------------------------
	logic [4:0]  s1_ff, s2_ff, s3_ff;  // pin synchronisers
	logic [4:0]  pin_ff;               // filtered pin levels
	logic [3:0]  ier_ff;               // interrupt_mask
	logic [7:0]  lcr_ff;               // line_format
	logic [4:0]  mcr_ff;               // modem_control
	logic [7:0]  dll_ff, dlm_ff;       // divisor latch
	logic [15:0] div_cnt_ff;           // 16x tick divider
	logic        tick;                 // one 16x clock
	asc_sel_t    sel_now, rd_sel_ff;   // decoded and captured read target
	logic [7:0]  prd_ff, rd_val;       // read snapshot
	logic        snap_dr_ff;           // data ready seen by the read
	logic        wr_acc, rd_setup, rd_acc;
	logic        isr_ack, lsr_ack, msr_ack, rhr_ack;
	logic [7:0]  thr_ff, tx_shift_ff;  // tx_holding and tx_shifter
	logic        thr_full_ff, wr_thr, tx_load, tx_par_ff, tx_line_ff, tx_end;
	asc_state_t  tx_state_ff, rx_state_ff;
	logic [5:0]  tx_tick_ff, stop_ticks;
	logic [2:0]  tx_bit_ff, rx_bit_ff, last_bit;
	logic        rx_line, rx_prev_ff, rx_par_ff, rx_done, rx_mid;
	logic [3:0]  rx_tick_ff;
	logic [7:0]  rx_shift_ff, rx_data, rhr_ff; // rx_shifter, rx_holding
	logic        dr_ff, oe_ff, pe_ff, fe_ff, bi_ff, ls_pend_ff, thre_pend_ff;
	logic        err_pe, err_fe, err_bi, rx_take;
	logic [3:0]  ms_now, ms_prev_ff, delta_ff;
	logic [3:0]  isr_code;
	logic        irq_ff, loop;

	assign loop = mcr_ff[MCR_LOOP];
	assign last_bit = 3'd4 + {1'b0, lcr_ff[1:0]}; // R12

	// ----------------------------------------------------------------
	// pin synchronisers: a change counts once stages two and three agree
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s1_ff <= PIN_RST;
			s2_ff <= PIN_RST;
			s3_ff <= PIN_RST;
			pin_ff <= PIN_RST;
		end else begin
			s1_ff <= {serial_in, carrier_detect_in_n, bell_signal_in_n, dsr_n, cts_n};
			s2_ff <= s1_ff;
			s3_ff <= s2_ff;
			pin_ff <= (~(s2_ff ^ s3_ff) & s3_ff) | ((s2_ff ^ s3_ff) & pin_ff);
		end
	end

	// ----------------------------------------------------------------
	// 16x tick from the divisor latch
	// ----------------------------------------------------------------
	assign tick = (div_cnt_ff == 16'h0000);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_cnt_ff <= 16'h0000;
		end else if (tick) begin
			// a zero divisor behaves as one rather than stalling
			div_cnt_ff <= ({dlm_ff, dll_ff} == 16'h0) ? 16'h0 : {dlm_ff, dll_ff} - 16'h1;
		end else begin
			div_cnt_ff <= div_cnt_ff - 16'h1;
		end
	end

	// ----------------------------------------------------------------
	// apb slave: zero wait; read data is snapshotted in the setup cycle
	// ----------------------------------------------------------------
	assign sel_now  = dec_reg(paddr, lcr_ff[LCR_DLAB]);
	assign wr_acc   = psel & penable & pwrite;
	assign rd_setup = psel & ~penable & ~pwrite;
	assign rd_acc   = psel & penable & ~pwrite;
	assign pready   = 1'b1;
	assign pslverr  = psel & penable & (sel_now == SEL_NONE);
	assign prdata   = {24'h000000, prd_ff};
	// read side effects only clear what the snapshot showed, except that any LSR read clears the pending line interrupt
	assign isr_ack  = rd_acc & (rd_sel_ff == SEL_ISR);
	assign lsr_ack  = rd_acc & (rd_sel_ff == SEL_LSR);
	assign msr_ack  = rd_acc & (rd_sel_ff == SEL_MSR);
	assign rhr_ack  = rd_acc & (rd_sel_ff == SEL_RHR) & snap_dr_ff; // R4

	// read mux
	always_comb begin
		case (sel_now)
			SEL_RHR: rd_val = rhr_ff; // R4
			SEL_IER: rd_val = {4'h0, ier_ff}; // R8
			SEL_ISR: rd_val = {4'h0, isr_code}; // R11
			SEL_LCR: rd_val = lcr_ff;
			SEL_MCR: rd_val = {3'h0, mcr_ff}; // R21
			SEL_LSR: rd_val = {1'b0, ~thr_full_ff & (tx_state_ff == ST_IDLE), ~thr_full_ff,
				bi_ff, fe_ff, pe_ff, oe_ff, dr_ff}; // R24
			SEL_MSR: rd_val = {ms_now, delta_ff};
			SEL_DLL: rd_val = dll_ff;
			SEL_DLM: rd_val = dlm_ff;
			default: rd_val = 8'h00;
		endcase
	end

	// snapshot of the addressed register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prd_ff <= 8'h00;
			rd_sel_ff <= SEL_NONE;
			snap_dr_ff <= 1'b0;
		end else if (rd_setup) begin
			prd_ff <= rd_val;
			rd_sel_ff <= sel_now;
			snap_dr_ff <= dr_ff;
		end else if (!psel) begin
			rd_sel_ff <= SEL_NONE;
		end
	end

	// control register writes
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ier_ff <= IER_RST;
			lcr_ff <= LCR_RST;
			mcr_ff <= MCR_RST;
			{dlm_ff, dll_ff} <= DIV_INIT;
		end else if (wr_acc) begin
			case (sel_now)
				SEL_IER: ier_ff <= pwdata[3:0]; // R8
				SEL_LCR: lcr_ff <= pwdata[7:0];
				SEL_MCR: mcr_ff <= pwdata[4:0]; // R21
				SEL_DLL: dll_ff <= pwdata[7:0];
				SEL_DLM: dlm_ff <= pwdata[7:0];
				default: ;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// transmitter
	// ----------------------------------------------------------------
	// a write while both holder and shifter are busy is dropped
	assign wr_thr = wr_acc & (sel_now == SEL_RHR) & (~thr_full_ff | (tx_state_ff == ST_IDLE)); // R1
	assign tx_load = thr_full_ff & (tx_state_ff == ST_IDLE);
	assign stop_ticks = !lcr_ff[LCR_STB] ? 6'(STOP1_TICKS) :
		(lcr_ff[1:0] == 2'b00) ? 6'(STOP15_TICKS) : 6'(STOP2_TICKS); // R13
	assign tx_end = tick & (tx_tick_ff == ((tx_state_ff == ST_STOP) ? stop_ticks - 6'd1 :
		6'(OVS_TICKS - 1)));

	// holding register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			thr_ff <= 8'h00;
			thr_full_ff <= 1'b0;
		end else if (wr_thr) begin
			thr_ff <= pwdata[7:0]; // R1
			thr_full_ff <= 1'b1;
		end else if (tx_load) begin
			thr_full_ff <= 1'b0; // R2
		end
	end

	// shift engine: start, data lsb first, parity, stop
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_state_ff <= ST_IDLE;
			tx_shift_ff <= 8'h00;
			tx_par_ff <= 1'b0;
			tx_bit_ff <= 3'h0;
			tx_tick_ff <= 6'h00;
		end else if (tx_load) begin
			tx_state_ff <= ST_START;
			tx_shift_ff <= thr_ff;
			tx_par_ff <= par_of(thr_ff, lcr_ff); // R15
			tx_bit_ff <= 3'h0;
			tx_tick_ff <= 6'h00;
		end else if (tick && tx_state_ff != ST_IDLE) begin
			tx_tick_ff <= tx_end ? 6'h00 : tx_tick_ff + 6'h01; // R26
			if (tx_end) begin
				case (tx_state_ff)
					ST_START: tx_state_ff <= ST_DATA;
					ST_DATA: begin
						tx_shift_ff <= tx_shift_ff >> 1;
						tx_bit_ff <= tx_bit_ff + 3'h1;
						if (tx_bit_ff == last_bit) begin
							tx_state_ff <= lcr_ff[LCR_PEN] ? ST_PAR : ST_STOP; // R14
						end
					end
					ST_PAR:  tx_state_ff <= ST_STOP;
					default: tx_state_ff <= ST_IDLE;
				endcase
			end
		end
	end

	// line level; break overrides everything
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_line_ff <= 1'b1;
		end else if (lcr_ff[LCR_BRK]) begin
			tx_line_ff <= 1'b0; // R17
		end else begin
			case (tx_state_ff)
				ST_START: tx_line_ff <= 1'b0;
				ST_DATA:  tx_line_ff <= tx_shift_ff[0]; // R26
				ST_PAR:   tx_line_ff <= tx_par_ff; // R14
				default:  tx_line_ff <= 1'b1;
			endcase
		end
	end

	// in loop-back the pin marks and the frame goes to the receiver
	assign serial_out = loop ? 1'b1 : tx_line_ff; // R21

	// ----------------------------------------------------------------
	// receiver
	// ----------------------------------------------------------------
	assign rx_line = loop ? tx_line_ff : pin_ff[PIN_RX];
	assign rx_mid  = tick & (rx_tick_ff == 4'(OVS_TICKS - 1));
	assign rx_done = rx_mid & (rx_state_ff == ST_STOP);
	assign rx_data = rx_shift_ff >> (2'd3 - lcr_ff[1:0]); // R12

	// frame engine; only the first stop bit is checked
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_state_ff <= ST_IDLE;
			rx_prev_ff <= 1'b1;
			rx_tick_ff <= 4'h0;
			rx_bit_ff <= 3'h0;
			rx_shift_ff <= 8'h00;
			rx_par_ff <= 1'b0;
		end else begin
			rx_prev_ff <= rx_line;
			case (rx_state_ff)
				ST_IDLE: if (rx_prev_ff && !rx_line) begin
					rx_state_ff <= ST_START; // R3
					rx_tick_ff <= 4'h0;
				end
				ST_START: if (tick) begin
					rx_tick_ff <= rx_tick_ff + 4'h1;
					if (rx_tick_ff == 4'(START_TICKS - 1)) begin
						// a glitch that is high again by mid-bit is dropped
						rx_state_ff <= rx_line ? ST_IDLE : ST_DATA; // R3
						rx_tick_ff <= 4'h0;
						rx_bit_ff <= 3'h0;
					end
				end
				ST_DATA: if (tick) begin
					rx_tick_ff <= rx_tick_ff + 4'h1;
					if (rx_mid) begin
						rx_shift_ff <= {rx_line, rx_shift_ff[7:1]}; // R26
						rx_bit_ff <= rx_bit_ff + 3'h1;
						if (rx_bit_ff == last_bit) begin
							rx_state_ff <= lcr_ff[LCR_PEN] ? ST_PAR : ST_STOP; // R14
						end
					end
				end
				ST_PAR: if (tick) begin
					rx_tick_ff <= rx_tick_ff + 4'h1;
					if (rx_mid) begin
						rx_par_ff <= rx_line;
						rx_state_ff <= ST_STOP;
					end
				end
				ST_STOP: if (tick) begin
					rx_tick_ff <= rx_tick_ff + 4'h1;
					if (rx_mid) begin
						rx_state_ff <= ST_IDLE;
					end
				end
				default: rx_state_ff <= ST_IDLE;
			endcase
		end
	end

	// character checks at the stop sample
	assign err_pe = lcr_ff[LCR_PEN] & (rx_par_ff != par_of(rx_data, lcr_ff)); // R14
	assign err_fe = ~rx_line;
	assign err_bi = (rx_data == 8'h00) & ~rx_line & ~(lcr_ff[LCR_PEN] & rx_par_ff);
	// a read popping in the same cycle makes room, so no overrun then
	assign rx_take = rx_done & (~dr_ff | rhr_ack);

	// holding register, data ready and error flags; a set beats a clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rhr_ff <= 8'h00;
			dr_ff <= 1'b0;
			oe_ff <= 1'b0;
			pe_ff <= 1'b0;
			fe_ff <= 1'b0;
			bi_ff <= 1'b0;
			ls_pend_ff <= 1'b0;
		end else begin
			if (rx_take) begin
				rhr_ff <= rx_data; // R4
			end
			dr_ff <= rx_take | (dr_ff & ~rhr_ack); // R24
			oe_ff <= (rx_done & ~rx_take) | (oe_ff & ~(lsr_ack & prd_ff[1])); // R25
			pe_ff <= (rx_done & err_pe) | (pe_ff & ~(lsr_ack & prd_ff[2]));
			fe_ff <= (rx_done & err_fe) | (fe_ff & ~(lsr_ack & prd_ff[3]));
			bi_ff <= (rx_done & err_bi) | (bi_ff & ~(lsr_ack & prd_ff[4]));
			ls_pend_ff <= (rx_done & (~rx_take | err_pe | err_fe | err_bi)) |
				(ls_pend_ff & ~lsr_ack & ~(isr_ack & (prd_ff[3:0] == ISR_LS))); // R9
		end
	end

	// ----------------------------------------------------------------
	// modem status and control outputs
	// ----------------------------------------------------------------
	always_comb begin
		if (loop) begin
			ms_now = {mcr_ff[MCR_IRQEN], mcr_ff[MCR_RING], mcr_ff[MCR_DTR],
				mcr_ff[MCR_RTS]}; // R22 R23
		end else begin
			ms_now = ~pin_ff[3:0];
		end
	end

	// change detection; ring reports only its trailing edge
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ms_prev_ff <= 4'h0;
			delta_ff <= 4'h0;
		end else begin
			ms_prev_ff <= ms_now;
			for (int i = 0; i < 4; i++) begin
				delta_ff[i] <= ((i == PIN_RI) ? (ms_prev_ff[i] & ~ms_now[i]) :
					(ms_prev_ff[i] ^ ms_now[i])) |
					(delta_ff[i] & ~(msr_ack & prd_ff[i]) &
					~(isr_ack & (prd_ff[3:0] == ISR_MS)));
			end
		end
	end

	// pins are active low; loop-back parks them inactive
	assign dtr_n = loop | ~mcr_ff[MCR_DTR]; // R19
	assign rts_n = loop | ~mcr_ff[MCR_RTS]; // R19

	// ----------------------------------------------------------------
	// interrupt source priority
	// ----------------------------------------------------------------
	// transmit-empty is an event: re-armed by unmasking while empty
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			thre_pend_ff <= 1'b0;
		end else begin
			thre_pend_ff <= tx_load | (wr_acc & (sel_now == SEL_IER) & pwdata[IER_TX] &
				~ier_ff[IER_TX] & ~thr_full_ff) |
				(thre_pend_ff & ~wr_thr & ~(isr_ack & (prd_ff[3:0] == ISR_TX))); // R6
		end
	end

	always_comb begin
		if (ier_ff[IER_LS] && ls_pend_ff) begin
			isr_code = ISR_LS; // R7 R10
		end else if (ier_ff[IER_RX] && dr_ff) begin
			isr_code = ISR_RX; // R5 R10
		end else if (ier_ff[IER_TX] && thre_pend_ff && !thr_full_ff) begin
			isr_code = ISR_TX; // R6 R10
		end else if (ier_ff[IER_MS] && (delta_ff != 4'h0)) begin
			isr_code = ISR_MS; // R8 R10
		end else begin
			isr_code = ISR_NONE; // R11
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_ff <= 1'b0;
		end else begin
			irq_ff <= (isr_code != ISR_NONE); // R11
		end
	end

	assign irq_o  = irq_ff;
	assign irq_oe = mcr_ff[MCR_IRQEN]; // R20

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	thr_capture_a: assert property (wr_thr |=> thr_full_ff && thr_ff == $past(pwdata[7:0])) // R1
		else $error("holding byte not captured");
	thre_flag_a: assert property (tx_load && !wr_thr |=> !thr_full_ff && tx_state_ff == ST_START) // R2
		else $error("holding empty flag not set on move");
	start_reject_a: assert property (rx_state_ff == ST_START && tick && rx_line &&
		rx_tick_ff == 4'(START_TICKS - 1) |=> rx_state_ff == ST_IDLE) // R3
		else $error("false start not dropped");
	rx_pop_a: assert property (rhr_ack && !rx_done |=> !dr_ff) // R4
		else $error("read did not remove byte");
	rx_irq_a: assert property (ier_ff[IER_RX] && dr_ff && !(ier_ff[IER_LS] && ls_pend_ff)
		|-> isr_code == ISR_RX ##1 irq_o) // R5
		else $error("receive ready interrupt missing");
	isr_idle_a: assert property (ier_ff == 4'h0 |-> isr_code == ISR_NONE ##1 !irq_o) // R11
		else $error("masked interrupt reported");
	break_line_a: assert property (lcr_ff[LCR_BRK] && !loop |=> !serial_out) // R17
		else $error("break not driven");
	loop_mirror_a: assert property (loop |-> ms_now[0] == mcr_ff[MCR_RTS] && dtr_n && rts_n) // R23
		else $error("loop-back status mismatch");
	overrun_keep_a: assert property (rx_done && dr_ff && !rhr_ack
		|=> oe_ff && rhr_ff == $past(rhr_ff)) // R25
		else $error("overrun corrupted holding byte");
	isr_clear_a: assert property (isr_ack && prd_ff[3:0] == ISR_TX && !tx_load
		|=> !thre_pend_ff) // R9
		else $error("source read did not clear");
endmodule : asc_top

// file: test/asc_remote.sv
// remote serial device model: frame sender and frame catcher at divisor 1
module asc_remote (
	input  wire logic pclk,
	input  wire logic line_in,
	output logic      line_out
);
	timeunit 1ns;
	timeprecision 1ps;
	localparam int BIT_T = 16;  // pclk cycles per bit with divisor 1
	// ------------------------------------------------------------
	// line driver and catcher
	// ------------------------------------------------------------
	initial line_out = 1'b1;  // idle high
	// frame bits go out in vector order, start first, lsb first
	task automatic send(input logic [11:0] f, input int len, input int bt);
		for (int i = 0; i < len; i++) begin
			@(posedge pclk);
			line_out <= f[i];
			repeat (bt - 1) @(posedge pclk);
		end
		@(posedge pclk);
		line_out <= 1'b1;  // back to idle, a short bt makes a false start
	endtask : send
	// samples at mid-bit after the falling edge; host pops data itself
	task automatic grab(input int len, output logic [11:0] f);
		f = '1;
		@(negedge line_in);
		repeat (BIT_T / 2) @(posedge pclk);
		for (int i = 0; i < len; i++) begin
			f[i] = line_in;  // mid-bit sample
			repeat (BIT_T) @(posedge pclk);
		end
	endtask : grab
endmodule : asc_remote

// file: test/asc_top_bench.sv
// self-checking bench for the serial channel over apb
module asc_top_bench;
	import asc_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, se;
	logic [4:0]  paddr = '0;
	logic [31:0] pwdata = '0, prdata, rd;
	logic        pready, pslverr, serial_in, serial_out, dtr_n, rts_n, irq_o, irq_oe;
	logic        cts_n = 1, dsr_n = 1, ri_n = 1, cd_n = 1;  // modem lines start inactive
	logic [11:0] fr;
	logic [7:0]  l, fmts [6] = '{8'h03, 8'h1a, 8'h09, 8'h2a, 8'h38, 8'h07};
	int          n_errors = 0, comparisons = 0, cycles = 0, n;
	localparam logic [4:0] A_DAT = {IDX_DATA, 2'b00}, A_IER = {IDX_IER, 2'b00};
	localparam logic [4:0] A_ISR = {IDX_ISR, 2'b00}, A_LCR = {IDX_LCR, 2'b00};
	localparam logic [4:0] A_MCR = {IDX_MCR, 2'b00}, A_LSR = {IDX_LSR, 2'b00};
	localparam logic [4:0] A_MSR = {IDX_MSR, 2'b00};
	always #12.5 pclk = ~pclk;
	asc_top u_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .serial_in(serial_in),
		.serial_out(serial_out), .cts_n(cts_n), .dsr_n(dsr_n),
		.bell_signal_in_n(ri_n), .carrier_detect_in_n(cd_n), .dtr_n(dtr_n),
		.rts_n(rts_n), .irq_o(irq_o), .irq_oe(irq_oe));
	asc_remote u_remote (.pclk(pclk), .line_in(serial_out), .line_out(serial_in));
	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	task automatic check(input string what, input logic [31:0] seen, exp);
		comparisons++;
		if (seen !== exp) begin
			n_errors++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	// one apb transfer; request held until pready is seen high
	task automatic apb(input logic [4:0] a, input logic w, input logic [7:0] d);
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		paddr   <= a;
		pwrite  <= w;
		pwdata  <= {24'h0, d};
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		se = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic rchk(input string what, input logic [4:0] a, input logic [31:0] exp);
		apb(a, 1'b0, 8'h00);
		check(what, rd, exp);
	endtask : rchk
	// expected frame: start low, data lsb first, optional parity, stop high
	function automatic logic [11:0] mk(input logic [7:0] d, input int n, pe, input logic p);
		logic [11:0] f;
		f = '1;
		f[0] = 1'b0;
		for (int i = 0; i < n; i++) f[i + 1] = d[i];
		if (pe != 0) f[n + 1] = p;
		return f;
	endfunction : mk
	task automatic conclude;
		$display("comparisons %0d errors %0d", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : conclude
	// hang guard, far above the few thousand cycles the run needs
	always @(posedge pclk) begin
		cycles++;
		if (cycles == 20000) begin
			n_errors++;
			conclude();
		end
	end
	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		check("idle pins", {dtr_n, rts_n, irq_oe, serial_out}, 4'b1101);
		rchk("mask reset", A_IER, 32'h00);
		rchk("source reset", A_ISR, 32'h01);
		rchk("format reset", A_LCR, 32'h00);
		rchk("status reset", A_LSR, 32'h60);
		apb(A_IER, 1'b1, 8'hf0);
		rchk("mask upper", A_IER, 32'h00);
		apb(A_MCR, 1'b1, 8'he3);
		@(negedge pclk);  // pins follow the register only after the write edge
		check("modem outs", {dtr_n, rts_n, irq_oe}, 3'b000);
		rchk("modem upper", A_MCR, 32'h03);
		apb(A_MCR, 1'b1, 8'h08);
		@(negedge pclk);
		check("irq enable", irq_oe, 1'b1);
		apb(A_LCR, 1'b1, 8'h80);
		apb(A_DAT, 1'b1, 8'h01);
		rchk("divisor low", A_DAT, 32'h01);
		// every length code, parity off, odd, even and both forced values
		foreach (fmts[k]) begin
			l = fmts[k];
			n = 5 + l[1:0];
			apb(A_LCR, 1'b1, l);
			apb(A_DAT, 1'b1, 8'h5a);
			fork
				u_remote.grab(n + 2 + l[3], fr);
				rchk("tx busy status", A_LSR, 32'h20);
			join
			check("tx frame", fr, mk(8'h5a, n, l[3], l[5] ? ~l[4] :
				(^(8'h5a & ~(8'hff << n))) ^ ~l[4]));
			// two stop bits keep the shifter busy past a one-stop frame
			rchk("tx stop", A_LSR, l[2] ? 32'h20 : 32'h60);
		end
		repeat (16) @(posedge pclk);
		rchk("tx done status", A_LSR, 32'h60);
		apb(A_LCR, 1'b1, 8'h43);
		repeat (2) @(posedge pclk);  // the line is registered behind the format
		check("break low", serial_out, 1'b0);
		apb(A_LCR, 1'b1, 8'h03);
		repeat (2) @(posedge pclk);
		check("break off", serial_out, 1'b1);
		u_remote.send(12'h000, 1, 4);
		repeat (300) @(posedge pclk);
		rchk("false start", A_LSR, 32'h60);
		u_remote.send(mk(8'h3c, 8, 0, 0), 10, 16);
		repeat (4) @(posedge pclk);
		rchk("rx ready", A_LSR, 32'h61);
		rchk("rx masked", A_ISR, 32'h01);
		apb(A_IER, 1'b1, 8'h03);
		rchk("top source", A_ISR, 32'h04);
		check("irq level", irq_o, 1'b1);
		rchk("rx level stays", A_ISR, 32'h04);
		rchk("rx data", A_DAT, 32'h3c);
		rchk("next source", A_ISR, 32'h02);
		rchk("none left", A_ISR, 32'h01);
		check("irq gone", irq_o, 1'b0);
		u_remote.send(mk(8'h11, 8, 0, 0), 10, 16);
		u_remote.send(mk(8'h22, 8, 0, 0), 10, 16);
		repeat (4) @(posedge pclk);
		apb(A_IER, 1'b1, 8'h0f);
		rchk("line source", A_ISR, 32'h06);
		rchk("overrun status", A_LSR, 32'h63);
		rchk("held byte", A_DAT, 32'h11);
		apb(A_LCR, 1'b1, 8'h1b);
		u_remote.send(mk(8'h3c, 8, 1, 1'b1), 11, 16);  // wrong even parity bit
		repeat (4) @(posedge pclk);
		rchk("parity error", A_LSR, 32'h65);
		rchk("parity data", A_DAT, 32'h3c);
		cts_n <= 1'b0;
		repeat (6) @(posedge pclk);  // pin synchroniser latency
		rchk("modem source", A_ISR, 32'h00);
		rchk("pin status", A_MSR, 32'h10);
		apb(A_MCR, 1'b1, 8'h1f);
		apb(A_MSR, 1'b0, 8'h00);
		check("loop status", rd, 32'hfa);
		check("loop pins", {serial_out, dtr_n, rts_n}, 3'b111);
		apb(5'h1c, 1'b0, 8'h00);
		check("unmapped error", {31'h0, se}, 32'h1);
		check("unmapped data", rd, 32'h0);
		conclude();
	end
endmodule : asc_top_bench
